//--- adc_conv_ctrl.sv
// Conversion control and output port of a successive-approximation converter.
// Assumes analog core supplies conv_result_in on ref_clk at conversion end;
// pins arrive asynchronously; Avalon-MM slave on ref_clk.
`timescale 1ns/1ps
module adc_conv_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter logic [1:0] WS_CODE_18 = 2'h0,
    parameter logic [1:0] WS_CODE_16 = 2'h1,
    parameter logic [1:0] WS_CODE_8 = 2'h2,
    parameter logic [CNT_W-1:0] DIV_HALF_0 = 8'h00,
    parameter logic [CNT_W-1:0] DIV_HALF_1 = 8'h01,
    parameter logic [CNT_W-1:0] DIV_HALF_2 = 8'h03,
    parameter logic [CNT_W-1:0] DIV_HALF_3 = 8'h07
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic conversion_start_n,
    input wire logic power_down_in,
    input wire logic chip_select_n,
    input wire logic read_enable_n,
    input wire logic refbuf_power_down,
    input wire logic output_coding_select,
    input wire logic width_select_0,
    input wire logic width_select_1,
    input wire logic clock_source_select,
    input wire logic read_mode_or_chain_in,
    input wire logic [1:0] serial_clock_divider,
    input wire logic [RESULT_BITS-1:0] conv_result_in,
    output logic conv_active,
    output logic busy,
    output logic analog_power_down,
    output logic refbuf_enable,
    output logic [RESULT_BITS-1:0] data_bus_out,
    output logic data_bus_oe,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import adc_ctrl_pkg::*;

    if (WS_CODE_18 == WS_CODE_16 || WS_CODE_18 == WS_CODE_8 || WS_CODE_16 == WS_CODE_8 ||
        WS_CODE_18 == WS_SERIAL || WS_CODE_16 == WS_SERIAL || WS_CODE_8 == WS_SERIAL)
    begin : g_ws_chk
        $error("adc_conv_ctrl: width-select codes must be distinct and not serial");
    end
    if (CONV_CYCLES < 1 || ACQ_CYCLES < 1 || CONV_CYCLES > 255 || ACQ_CYCLES > 255)
    begin : g_cnt_chk
        $error("adc_conv_ctrl: cycle counts out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    pin_type pins;
    logic prev_start_n;
    logic [CNT_W-1:0] count;
    logic have_result;
    logic [RESULT_BITS-1:0] result;
    ctrl_type ctrl;
    state_type state;
    state_type next_state;
    logic sclk_raw;
    logic frame_raw;
    logic sdo_raw;
    logic shift_done;

    level_sync #(
        .WIDTH(PIN_BITS),
        .RESET_VAL(PIN_IDLE)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in({conversion_start_n, power_down_in, chip_select_n, read_enable_n,
                   refbuf_power_down, output_coding_select, width_select_1,
                   width_select_0, clock_source_select, read_mode_or_chain_in,
                   serial_clock_divider}),
        .sync_out(pins)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode
    wire [1:0] ws_code = {pins.ws1, pins.ws0};
    wire serial_mode = ws_code == WS_SERIAL; // [R12]
    wire par18 = ws_code == WS_CODE_18; // [R25]
    wire par16 = ws_code == WS_CODE_16; // [R25]
    wire master = serial_mode && !pins.ext_clk; // [R15]
    wire read_during = master && pins.rdc; // [R18]
    wire read_after = master && !pins.rdc; // [R18]
    wire low_power = ctrl.mode == MODE_LOW_POWER;
    // Start strobe is a falling edge, not gated by select or read [R02]
    wire start_fall = prev_start_n && !pins.start_n; // [R02]
    wire conv_end = state == ST_CONVERT && count == '0;
    wire acq_end = state == ST_ACQUIRE && count == '0;
    // Self-restart only in low-power mode with start still held low [R03] [R05]
    wire auto_next = low_power && !pins.start_n; // [R03] [R05]
    wire launch = state == ST_IDLE && start_fall && !pins.pd;

    // Output coding: twos complement flips the MSB, never in 18-bit parallel [R07]
    wire use_tc = !pins.coding && !par18; // [R07]
    wire [RESULT_BITS-1:0] code_flip = use_tc ? TC_FLIP : '0;
    wire [RESULT_BITS-1:0] held_coded = result ^ code_flip;
    wire [RESULT_BITS-1:0] new_coded = conv_result_in ^ code_flip;

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (launch) begin
                    next_state = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                // Only the internal timer ends a conversion [R01]
                if (conv_end) begin
                    if (read_after) begin
                        next_state = ST_SHIFT; // [R19]
                    end else if (auto_next) begin
                        next_state = ST_ACQUIRE; // [R03]
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_SHIFT: begin
                if (shift_done) begin
                    next_state = auto_next ? ST_ACQUIRE : ST_IDLE; // [R03]
                end
            end
            ST_ACQUIRE: begin
                if (acq_end) begin
                    next_state = ST_CONVERT; // [R03]
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    wire enter_conv = next_state == ST_CONVERT && state != ST_CONVERT;
    wire enter_acq = next_state == ST_ACQUIRE && state != ST_ACQUIRE;
    // Serial launch: previous result at conversion start, or new one at its end
    wire shift_start = (enter_conv && read_during && have_result) ||
                       (conv_end && read_after); // [R10] [R18]
    wire [RESULT_BITS-1:0] shift_data = conv_end ? new_coded : held_coded;

    // State, timer and result hold
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            count <= '0;
            prev_start_n <= 1'b1;
            result <= '0;
            have_result <= 1'b0;
        end else begin
            state <= next_state;
            prev_start_n <= pins.start_n;
            if (enter_conv) begin
                count <= CNT_W'(CONV_CYCLES - 1);
            end else if (enter_acq) begin
                count <= CNT_W'(ACQ_CYCLES - 1); // [R03]
            end else if (count != '0) begin
                count <= count - 1'b1;
            end
            if (conv_end) begin
                result <= conv_result_in; // [R23]
                have_result <= 1'b1;
            end
        end
    end

    // Busy, analog phase and power outputs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            conv_active <= 1'b0;
            analog_power_down <= 1'b0;
            refbuf_enable <= 1'b0;
        end else begin
            busy <= next_state == ST_CONVERT || next_state == ST_SHIFT; // [R19] [R23]
            conv_active <= next_state == ST_CONVERT;
            // Power drops outside conversion in low-power mode or with power-down high; the port logic keeps running [R22]
            analog_power_down <= next_state != ST_CONVERT && (low_power || pins.pd); // [R22]
            refbuf_enable <= !pins.refbuf_pd; // [R21]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial master port
    wire [CNT_W-1:0] half_cycles = pins.div == 2'd0 ? DIV_HALF_0 :
                                   pins.div == 2'd1 ? DIV_HALF_1 :
                                   pins.div == 2'd2 ? DIV_HALF_2 : DIV_HALF_3; // [R26]

    serial_master #(
        .DATA_BITS(RESULT_BITS),
        .HALF_W(CNT_W)
    ) u_serial (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .start(shift_start),
        .data(shift_data),
        .half_cycles(half_cycles), // [R20]
        .sclk(sclk_raw),
        .frame(frame_raw),
        .sdo(sdo_raw),
        .done(shift_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output bus selection
    wire [RESULT_BITS-1:0] bus16 = ctrl.part_sel[0] ? {16'h0000, held_coded[1:0]}
                                                   : {2'h0, held_coded[17:2]};
    wire [7:0] byte_sel = ctrl.part_sel == 2'd0 ? held_coded[17:10] :
                          ctrl.part_sel == 2'd1 ? held_coded[9:2] :
                          ctrl.part_sel == 2'd2 ? {held_coded[1:0], 6'h00} : 8'h00;
    logic [RESULT_BITS-1:0] serial_pins;
    always_comb begin
        serial_pins = '0;
        serial_pins[PIN_SDO] = sdo_raw; // [R08]
        serial_pins[PIN_SCLK] = master && (sclk_raw ^ ctrl.sclk_inv); // [R15] [R17]
        serial_pins[PIN_SYNC] = master && (frame_raw ^ ctrl.sync_inv); // [R16] [R17]
    end
    wire [RESULT_BITS-1:0] next_bus = serial_mode ? serial_pins : // [R08]
                                      par18 ? held_coded :
                                      par16 ? bus16 :
                                      {10'h000, byte_sel}; // [R09]

    // Bus drivers enabled only with select and read both low
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            data_bus_out <= '0;
            data_bus_oe <= 1'b0;
        end else begin
            data_bus_out <= next_bus; // [R10]
            data_bus_oe <= !pins.cs_n && !pins.rd_n; // [R06]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave, one wait cycle per access
    wire req = avs_read || avs_write;
    wire accept = req && !avs_waitrequest;
    wire [31:0] status_word = {24'h000000, state, 2'b00, have_result, busy};
    wire [31:0] read_word = avs_address == CTRL_ADDR ? {26'h0, ctrl} :
                            avs_address == STATUS_ADDR ? status_word :
                            avs_address == RESULT_ADDR ? {14'h0, held_coded} : 32'h0;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= '0;
            ctrl <= ctrl_type'(CTRL_RESET);
        end else begin
            avs_waitrequest <= !(req && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= read_word;
            end
            if (accept && avs_write && avs_address == CTRL_ADDR && avs_byteenable[0]) begin
                ctrl <= ctrl_type'(avs_writedata[CTRL_BITS-1:0]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_no_restart: assert property (state == ST_CONVERT && count != '0 |=> state == ST_CONVERT) // [R01]
        else $error("conversion ended early");
    chk_acq_timed: assert property ($rose(state == ST_ACQUIRE) |-> (state == ST_ACQUIRE)[*7] ##1 state == ST_CONVERT) // [R03]
        else $error("acquisition not timed correctly");
    chk_auto_lp_only: assert property ($rose(state == ST_ACQUIRE) |-> $past(ctrl.mode) == MODE_LOW_POWER) // [R05]
        else $error("self restart outside low-power mode");
    chk_hiz_deselect: assert property ((pins.cs_n || pins.rd_n) |=> !data_bus_oe) // [R06]
        else $error("bus driven while deselected");
    chk_busy_shift: assert property (state == ST_SHIFT && !shift_done |=> busy) // [R19]
        else $error("busy low while bits still leaving");
    chk_result_ready: assert property ($fell(busy) |-> have_result && $past(state) != ST_IDLE) // [R23]
        else $error("busy fell without a result");
    chk_refbuf_follow: assert property (rst_n |=> refbuf_enable == !$past(pins.refbuf_pd)) // [R21]
        else $error("reference buffer enable wrong");
    chk_lp_power: assert property (low_power && state == ST_IDLE && !launch |=> analog_power_down) // [R22]
        else $error("analog power kept on in low-power idle");
endmodule : adc_conv_ctrl

//--- adc_ctrl_pkg.sv
// Constants, types and field layouts of the converter control block.
// Assumes a 10 MHz ref_clk and word-aligned Avalon-MM byte addresses.
// Summary of operation
// R01 - A launched conversion always completes; start strobes and power-down cannot stop it.
// R02 - The start input works regardless of chip select and read enable.
// R03 - Low-power mode with start held low: timed acquisition, then automatic conversion.
// R04 - Host pulses start once after power-up and settles input when busy falls.
// R05 - Automatic restart exists only in low-power mode; rate may exceed nominal.
// R06 - Output drivers float unless chip select and read enable are both low.
// R07 - Coding select picks binary or twos complement, except 18-bit parallel.
// R08 - Serial signals share the parallel data bus pins.
// R09 - Parallel results leave over 18, 16 or 8 bit bus widths.
// R10 - Result readable after conversion, in acquisition, or during next conversion.
// R11 - Host should finish reads during conversion in its first half.
// R12 - Both width selects high choose the serial port.
// R13 - Serial port sends 18 bits, MSB first, one per serial clock pulse.
// R14 - Serial data stays valid across both serial clock edges.
// R15 - Clock source select low makes the device generate the serial clock.
// R16 - As master the device drives a frame-valid strobe around the data.
// R17 - Serial clock and frame strobe polarity are configurable.
// R18 - Read mode input picks send-after-conversion or previous-during-conversion.
// R19 - Master read-after-conversion keeps busy high until all 18 bits leave.
// R20 - Divider inputs slow the generated serial clock.
// R21 - Reference buffer runs while its power-down input is low.
// R22 - Low-power mode cuts analog power after conversion; interface stays live.
// R23 - Busy falling marks completion; the new result is readable from then.
// R24 - In fast mode the host drops the first result after a long pause.
// R25 - Width-select codes for 18, 16 and 8 bit buses are configurable.
// R26 - Divider ratios are parameters; by default each divider step doubles the serial clock half period.
package adc_ctrl_pkg;
    localparam int RESULT_BITS = 18;
    localparam int CLK_HZ = 10_000_000;
    // Conversion and acquisition times in ns, rounded up to cycles
    localparam int CONV_TIME_NS = 1000;
    localparam int ACQ_TIME_NS = 700;
    localparam int CYCLE_NS = 1_000_000_000 / CLK_HZ;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CYCLE_NS - 1) / CYCLE_NS;
    localparam int ACQ_CYCLES = (ACQ_TIME_NS + CYCLE_NS - 1) / CYCLE_NS;
    localparam int CNT_W = 8;
    // Register byte offsets
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam logic [3:0] RESULT_ADDR = 4'h8;
    localparam int CTRL_BITS = 6;
    localparam logic [CTRL_BITS-1:0] CTRL_RESET = 6'h00;
    // Width-select code that always means serial
    localparam logic [1:0] WS_SERIAL = 2'h3;
    // Data bus pins carrying the serial signals
    localparam int PIN_SDO = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_SYNC = 2;
    localparam logic [RESULT_BITS-1:0] TC_FLIP = 18'h20000;
    localparam int PIN_BITS = 12;
    // Pin levels held in the synchroniser during reset: start, select, read high, binary coding
    localparam logic [PIN_BITS-1:0] PIN_IDLE = 12'hb40;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_FAST = 2'h1,
        MODE_LOW_POWER = 2'h2
    } op_mode_type;

    // Software control word, bit 0 upward: mode, clock invert, strobe invert, part select
    typedef struct packed {
        logic [1:0] part_sel;
        logic sync_inv;
        logic sclk_inv;
        op_mode_type mode;
    } ctrl_type;

    // Synchronised pin levels
    typedef struct packed {
        logic start_n;
        logic pd;
        logic cs_n;
        logic rd_n;
        logic refbuf_pd;
        logic coding;
        logic ws1;
        logic ws0;
        logic ext_clk;
        logic rdc;
        logic [1:0] div;
    } pin_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CONVERT = 4'b0010,
        ST_SHIFT = 4'b0100,
        ST_ACQUIRE = 4'b1000
    } state_type;
endpackage : adc_ctrl_pkg

//--- level_sync.sv
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes inputs are quasi-static levels from pins.
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage;

    // First stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            // Idle pin levels, so no false edge or select follows reset
            stage <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            stage <= async_in;
            sync_out <= stage;
        end
    end
endmodule : level_sync

//--- serial_master.sv
// Serial master shifter: 18 pulses MSB first with a frame strobe.
// Assumes one-cycle start pulse; data sampled at start.
`timescale 1ns/1ps
module serial_master #(
    parameter int DATA_BITS = 18,
    parameter int HALF_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [DATA_BITS-1:0] data,
    input wire logic [HALF_W-1:0] half_cycles,
    output logic sclk,
    output logic frame,
    output logic sdo,
    output logic done
);
    logic [DATA_BITS-1:0] shreg;
    logic [5:0] bit_cnt;
    logic [1:0] phase;
    logic [HALF_W-1:0] tick;
    logic [5:0] rise_cnt;
    wire last_bit = bit_cnt == 6'(DATA_BITS - 1);

    if (DATA_BITS < 2 || DATA_BITS > 63) begin : g_chk
        $error("serial_master: DATA_BITS out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Each bit: data set, low, high, low, then next data [R14]
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            shreg <= '0;
            bit_cnt <= '0;
            phase <= '0;
            tick <= '0;
            sclk <= 1'b0;
            frame <= 1'b0;
            sdo <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!frame) begin
                if (start) begin
                    frame <= 1'b1; // [R16]
                    shreg <= data;
                    sdo <= data[DATA_BITS-1]; // MSB first [R13]
                    bit_cnt <= '0;
                    phase <= '0;
                    tick <= half_cycles; // [R20]
                end
            end else if (tick != '0) begin
                tick <= tick - 1'b1;
            end else begin
                tick <= half_cycles;
                case (phase)
                    2'd0: begin
                        sclk <= 1'b1;
                        phase <= 2'd1;
                    end
                    2'd1: begin
                        sclk <= 1'b0;
                        phase <= 2'd2;
                    end
                    default: begin
                        if (last_bit) begin
                            frame <= 1'b0;
                            done <= 1'b1;
                        end else begin
                            bit_cnt <= bit_cnt + 1'b1;
                            shreg <= shreg << 1;
                            sdo <= shreg[DATA_BITS-2]; // [R13]
                            phase <= 2'd0;
                        end
                    end
                endcase
            end
        end
    end

    // Helper: rising clock edges in the current frame
    always_ff @(posedge ref_clk) begin
        if (!rst_n || (start && !frame)) begin
            rise_cnt <= '0;
        end else if (frame && tick == '0 && phase == 2'd0) begin
            rise_cnt <= rise_cnt + 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_sdo_both_edges: assert property (($rose(sclk) || $fell(sclk)) |-> $stable(sdo)) // [R14]
        else $error("serial data changed on a clock edge");
    chk_pulse_count: assert property ($rose(done) |-> rise_cnt == 6'(DATA_BITS)) // [R13]
        else $error("frame did not carry the full pulse count");
endmodule : serial_master

//--- host_rx.sv
// Host model listening to the master serial port on the shared data pins.
// Assumes non-inverted serial clock and an active-high frame strobe.
`timescale 1ns/1ps
module host_rx
    import adc_ctrl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [RESULT_BITS-1:0] bus,
    input wire logic oe,
    output logic [RESULT_BITS-1:0] word,
    output logic got
);
    logic sclk_d;
    logic frame_d;
    int n_bits = 0;
    // Shift in on each rising serial clock; flag a full word when a driven frame ends
    always @(posedge ref_clk) begin
        sclk_d <= bus[PIN_SCLK];
        frame_d <= bus[PIN_SYNC];
        got <= oe && frame_d && !bus[PIN_SYNC] && n_bits == RESULT_BITS;
        if (bus[PIN_SYNC] && !frame_d) begin
            n_bits <= 0;
        end else if (oe && bus[PIN_SYNC] && bus[PIN_SCLK] && !sclk_d) begin
            n_bits <= n_bits + 1;
            word <= {word[RESULT_BITS-2:0], bus[PIN_SDO]};
        end
    end
endmodule : host_rx

//--- adc_conv_ctrl_test.sv
// Self-checking bench for the converter control block.
// Assumes the host model on the serial pins and a 10 MHz clock.
`timescale 1ns/1ps
module adc_conv_ctrl_test;
    import adc_ctrl_pkg::*;
    logic ref_clk = 0, rst_n = 0, start_n = 1, pd = 0, cs_n = 1, rd_n = 1, rbpd = 0;
    logic coding = 1, ext = 0, rdc = 0, rd = 0, wr = 0;
    logic [1:0] ws = 2'h0, div = 2'h0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [17:0] res = 18'h0, dbus, word, cres;
    logic busy, act, apd, rbe, oe, wq, got;
    int n_fail = 0, tests_run = 0, cyc = 0, rises = 0, hi = 0, last_w = 0, r0;
    logic [31:0] exp_q[$], got_q[$];
    event got_ev;
    //////////////////////////////
    always #50 ref_clk = ~ref_clk;
    adc_conv_ctrl adc_conv_ctrl_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .conversion_start_n(start_n), .power_down_in(pd), .chip_select_n(cs_n),
        .read_enable_n(rd_n), .refbuf_power_down(rbpd), .output_coding_select(coding),
        .width_select_0(ws[0]), .width_select_1(ws[1]), .clock_source_select(ext),
        .read_mode_or_chain_in(rdc), .serial_clock_divider(div), .conv_result_in(res),
        .conv_active(act), .busy(busy), .analog_power_down(apd), .refbuf_enable(rbe),
        .data_bus_out(dbus), .data_bus_oe(oe), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hf),
        .avs_readdata(rdata), .avs_waitrequest(wq));
    host_rx host_rx_inst (.ref_clk(ref_clk), .bus(dbus), .oe(oe), .word(word), .got(got));
    //////////////////////////////
    task check(input logic [31:0] v, input logic [31:0] e);
        tests_run++;
        if (v !== e) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, v, e);
        end
    endtask : check
    task close_out;
        if (exp_q.size() != 0 || got_q.size() != 0) n_fail++;
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    task note(input logic [31:0] e);
        exp_q.push_back(e);
    endtask : note
    task seen(input logic [31:0] v);
        got_q.push_back(v);
        -> got_ev;
    endtask : seen
    // Bus cycle held until waitrequest is sampled low
    task av(input logic w_en, input logic [3:0] a, input logic [31:0] d);
        wr <= w_en;
        rd <= !w_en;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        while (wq !== 1'b0) @(posedge ref_clk);
        if (!w_en) seen(rdata);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge ref_clk);
    endtask : av
    // Start strobe held for a number of cycles, then wait for a busy fall
    task conv(input int hold, input logic pdx);
        r0 = rises;
        start_n <= 1'b0;
        repeat (hold) @(posedge ref_clk);
        start_n <= 1'b1;
        pd <= pdx;
        while (rises == r0) @(posedge ref_clk);
        pd <= 1'b0;
        @(posedge ref_clk);
    endtask : conv
    //////////////////////////////
    // Oldest note against each observed result
    always @(got_ev) begin
        while (got_q.size() > 0 && exp_q.size() > 0) begin
            check(got_q.pop_front(), exp_q.pop_front());
        end
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (act === 1'b1) check({31'h0, busy}, 32'h1);
        if (got === 1'b1) seen({14'h0, word});
        if (busy === 1'b1) hi <= hi + 1;
        else if (hi != 0) begin
            last_w <= hi;
            hi <= 0;
            rises <= rises + 1;
        end
        if (cyc == 5000) begin
            n_fail++;
            close_out;
        end
    end
    //////////////////////////////
    initial begin
        void'($urandom(1));
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        note(32'h0);
        av(1'b0, CTRL_ADDR, 32'h0);
        av(1'b1, 4'hc, 32'hff);
        note(32'h0);
        av(1'b0, 4'hc, 32'h0);
        rbpd <= 1'b1;
        repeat (4) @(posedge ref_clk);
        note(32'h0);
        seen({31'h0, rbe});
        rbpd <= 1'b0;
        repeat (4) @(posedge ref_clk);
        note(32'h1);
        seen({31'h0, rbe});
        // Parallel widths and coding; power-down raised mid-conversion
        for (int i = 0; i < 3; i++) begin
            res <= 18'($urandom);
            ws <= 2'(i);
            coding <= (i == 1);
            @(posedge ref_clk);
            cres = (i == 2) ? (res ^ TC_FLIP) : res;
            conv(6, 1'b1);
            note(CONV_CYCLES);
            seen(last_w);
            note({14'h0, cres});
            av(1'b0, RESULT_ADDR, 32'h0);
            cs_n <= 1'b0;
            rd_n <= 1'b0;
            repeat (4) @(posedge ref_clk);
            note((i == 0) ? {14'h0, cres} : (i == 1) ? {16'h0, cres[17:2]} :
                 {24'h0, cres[17:10]});
            seen({14'h0, dbus});
            note(32'h1);
            seen({31'h0, oe});
            cs_n <= 1'b1;
            repeat (4) @(posedge ref_clk);
            note(32'h0);
            seen({31'h0, oe});
        end
        // Start held low in fast mode gives one conversion only; only the busy fall count is checked
        av(1'b1, CTRL_ADDR, 32'h1);
        r0 = rises;
        conv(30, 1'b0);
        note(32'h1);
        seen(rises - r0);
        // Serial master, read after conversion, two divider settings
        ws <= WS_SERIAL;
        cs_n <= 1'b0;
        for (int d = 0; d < 2; d++) begin
            res <= 18'($urandom);
            div <= 2'(d);
            @(posedge ref_clk);
            note({14'h0, res ^ TC_FLIP});
            conv(3, 1'b0);
            note(32'h1);
            seen(last_w > CONV_CYCLES + 54 * (d + 1));
            repeat (10) @(posedge ref_clk);
        end
        // Low-power mode restarts on its own while start stays low
        cs_n <= 1'b1;
        ws <= 2'h0;
        av(1'b1, CTRL_ADDR, 32'h2);
        r0 = rises;
        conv(50, 1'b0);
        note(32'h1);
        seen(rises - r0 >= 2);
        note(32'h1);
        seen({31'h0, apd});
        repeat (30) @(posedge ref_clk);
        close_out;
    end
endmodule : adc_conv_ctrl_test
